// File: rtl/ftonp_pkg.sv
// shared constants and types of the terminal overhead and nibble port
package ftonp_pkg;
  // ***********************************************
  // widths
  // ***********************************************
  localparam int NIBBLE_W  = 4;
  localparam int PKT_W     = 8;
  localparam int SYNC_LEN  = 2;
  // ***********************************************
  // packet byte bit positions on shared pins
  // ***********************************************
  localparam int PKT_BIT_OH_VALID = 5;
  localparam int PKT_BIT_NIB0     = 0;
  localparam int PKT_BIT_NIB3     = 3;
  localparam int PKT_BIT_INSERT   = 4;
  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [NIBBLE_W-1:0] NIBBLE_RST = 4'h0;
  localparam logic [PKT_W-1:0]    PKT_RST    = 8'h00;
  // transmit overhead sequencer states
  typedef enum logic [1:0] {
    FTONP_TX_IDLE,
    FTONP_TX_WINDOW,
    FTONP_TX_RETURN
  } ftonp_tx_state_type;
endpackage : ftonp_pkg

// File: rtl/ftonp_port.sv
// terminal side overhead and nibble pin port of one framer channel
// How it works
// - with insert request high outside packet mode, the terminal overhead bit is taken at strobe fall.
// - with insert request low, the terminal overhead bit is ignored.
// - insert requests on non-insertable overhead bits are ignored; default kept.
// - outside packet mode, receive overhead valid pulses for exactly one link clock period.
// - packet mode puts byte bit 5 on the valid pin and byte bits 0 to 3 on the nibble pins.
// - received payload leaves as one 4-bit nibble on lines 0 to 3.
// - nibble lines change only on rising link clock edges.
// - nibble lines carry payload only in nibble-parallel mode.
// - overhead window output high one link period before each sample, except in packet mode, where it stays low.
// - strobe clock rises one period before every overhead bit, insertable or not.
`timescale 1ns/1ps
`default_nettype none
module ftonp_port
  import ftonp_pkg::*;
(
  // system clock domain
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // link clock from the terminal
  input  wire logic                transmit_input_clock,
  // channel configuration, system domain
  input  wire logic                pkt_enable,
  input  wire logic                nibble_mode,
  // overhead bit requests from the framer core
  input  wire logic                core_oh_valid,
  input  wire logic                core_oh_insertable,
  input  wire logic                core_oh_default,
  output logic                     core_oh_ready,
  output logic                     core_oh_done,
  output logic                     core_oh_value,
  // receive data from the framer core
  input  wire logic                core_rx_valid,
  input  wire logic                core_rx_oh_flag,
  input  wire logic                core_rx_oh_bit,
  input  wire logic [NIBBLE_W-1:0] core_rx_nibble,
  input  wire logic [PKT_W-1:0]    core_rx_pkt_byte,
  output logic                     core_rx_ready,
  output logic                     core_tx_pkt_bit4,
  // transmit overhead pins
  input  wire logic                overhead_insert_request,
  input  wire logic                tx_overhead_bit_in,
  output logic                     overhead_strobe_clock,
  input  wire logic                overhead_window_in,
  output logic                     overhead_window_out,
  output logic                     overhead_window_oe,
  // receive pins
  output logic                     rx_overhead_valid,
  output logic                     rx_overhead_bit_out,
  output logic [NIBBLE_W-1:0]      rx_nibble_line
);
  localparam int RX_W = 2 + NIBBLE_W + PKT_W;
  logic               link_rst_s1;
  logic               link_rst;
  logic               pkt_s1;
  logic               pkt_l;
  logic               nib_s1;
  logic               nib_l;
  logic               bit4_s1;
  logic               bit4_s2;
  ftonp_tx_state_type tx_state;
  logic               tx_insertable;
  logic               tx_default;
  logic               tx_value;
  logic               oh_pulse;
  logic [PKT_W-1:0]   rx_byte;
  logic               rx_oh_bit;
  logic [NIBBLE_W-1:0] rx_nib;

  ftonp_xfer_if #(.WIDTH(2))    tx_req ();
  ftonp_xfer_if #(.WIDTH(1))    tx_res ();
  ftonp_xfer_if #(.WIDTH(RX_W)) rx_x ();
  // ***********************************************
  // reset and configuration into the link domain
  // ***********************************************
  always_ff @(posedge transmit_input_clock) begin
    link_rst_s1 <= sys_rst;
    link_rst    <= link_rst_s1;
  end

  always_ff @(posedge transmit_input_clock) begin
    if (link_rst) begin
      pkt_s1 <= 1'b0;
      pkt_l  <= 1'b0;
      nib_s1 <= 1'b0;
      nib_l  <= 1'b0;
    end else begin
      pkt_s1 <= pkt_enable;
      pkt_l  <= pkt_s1;
      nib_s1 <= nibble_mode;
      nib_l  <= nib_s1;
    end
  end

  // packet bit 4 shares the insert request pin
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bit4_s1 <= 1'b0;
      bit4_s2 <= 1'b0;
    end else begin
      bit4_s1 <= overhead_insert_request;
      bit4_s2 <= bit4_s1;
    end
  end
  assign core_tx_pkt_bit4 = bit4_s2;

  // ***********************************************
  // domain crossings
  // ***********************************************
  assign tx_req.src_valid = core_oh_valid;
  assign tx_req.src_data  = {core_oh_insertable, core_oh_default};
  assign core_oh_ready    = tx_req.src_ready;
  assign core_oh_done     = tx_res.dst_valid;
  assign core_oh_value    = tx_res.dst_data[0];
  assign rx_x.src_valid   = core_rx_valid;
  assign rx_x.src_data    = {core_rx_oh_flag, core_rx_oh_bit, core_rx_nibble, core_rx_pkt_byte};
  assign core_rx_ready    = rx_x.src_ready;

  ftonp_xfer #(.WIDTH(2)) u_tx_req (
    .src_clk (sys_clk),
    .src_rst (sys_rst),
    .dst_clk (transmit_input_clock),
    .dst_rst (link_rst),
    .port    (tx_req)
  );
  ftonp_xfer #(.WIDTH(1)) u_tx_res (
    .src_clk (transmit_input_clock),
    .src_rst (link_rst),
    .dst_clk (sys_clk),
    .dst_rst (sys_rst),
    .port    (tx_res)
  );
  ftonp_xfer #(.WIDTH(RX_W)) u_rx (
    .src_clk (sys_clk),
    .src_rst (sys_rst),
    .dst_clk (transmit_input_clock),
    .dst_rst (link_rst),
    .port    (rx_x)
  );

  // ***********************************************
  // transmit overhead sequencer
  // ***********************************************
  always_ff @(posedge transmit_input_clock) begin
    if (link_rst) begin
      tx_state              <= FTONP_TX_IDLE;
      tx_insertable         <= 1'b0;
      tx_default            <= 1'b0;
      tx_value              <= 1'b0;
      overhead_window_out   <= 1'b0;
      overhead_strobe_clock <= 1'b0;
    end else begin
      case (tx_state)
        FTONP_TX_IDLE: begin
          // strobe rises for every overhead bit
          if (tx_req.dst_valid) begin
            tx_insertable         <= tx_req.dst_data[1];
            tx_default            <= tx_req.dst_data[0];
            // window one period ahead of sampling
            overhead_window_out   <= ~pkt_l;
            overhead_strobe_clock <= 1'b1;
            tx_state              <= FTONP_TX_WINDOW;
          end
        end
        FTONP_TX_WINDOW: begin
          overhead_window_out   <= 1'b0;
          overhead_strobe_clock <= 1'b0;
          if (overhead_insert_request && tx_insertable && !pkt_l) begin
            tx_value <= tx_overhead_bit_in;
          end else begin
            tx_value <= tx_default;
          end
          tx_state <= FTONP_TX_RETURN;
        end
        FTONP_TX_RETURN: begin
          if (tx_res.src_ready) begin
            tx_state <= FTONP_TX_IDLE;
          end
        end
        default: begin
          tx_state <= FTONP_TX_IDLE;
        end
      endcase
    end
  end
  assign tx_res.src_valid = (tx_state == FTONP_TX_RETURN) && tx_res.src_ready;
  assign tx_res.src_data  = tx_value;
  // shared window pin driven only without packet controller
  always_ff @(posedge transmit_input_clock) begin
    if (link_rst) begin
      overhead_window_oe <= 1'b1;
    end else begin
      overhead_window_oe <= ~pkt_l;
    end
  end

  // ***********************************************
  // receive path
  // ***********************************************
  always_ff @(posedge transmit_input_clock) begin
    if (link_rst) begin
      oh_pulse  <= 1'b0;
      rx_oh_bit <= 1'b0;
      rx_nib    <= NIBBLE_RST;
      rx_byte   <= PKT_RST;
    end else begin
      oh_pulse <= rx_x.dst_valid && rx_x.dst_data[RX_W-1];
      // nibbles move only on rising edges
      if (rx_x.dst_valid) begin
        rx_oh_bit <= rx_x.dst_data[RX_W-2];
        rx_byte   <= rx_x.dst_data[PKT_W-1:0];
        // one nibble on lines 0 to 3
        rx_nib    <= nib_l ? rx_x.dst_data[PKT_W +: NIBBLE_W] : NIBBLE_RST;
      end
    end
  end

  // packet byte bits on shared receive pins
  always_ff @(posedge transmit_input_clock) begin
    if (link_rst) begin
      rx_overhead_valid   <= 1'b0;
      rx_overhead_bit_out <= 1'b0;
      rx_nibble_line      <= NIBBLE_RST;
    end else if (pkt_l) begin
      rx_overhead_valid   <= rx_byte[PKT_BIT_OH_VALID];
      rx_overhead_bit_out <= 1'b0;
      rx_nibble_line      <= rx_byte[PKT_BIT_NIB3:PKT_BIT_NIB0];
    end else begin
      rx_overhead_valid   <= oh_pulse;
      rx_overhead_bit_out <= rx_oh_bit;
      rx_nibble_line      <= rx_nib;
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  AST_WINDOW_ONE_PERIOD: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    overhead_window_out |-> (tx_state == FTONP_TX_WINDOW) ##1
      (!overhead_window_out && tx_state == FTONP_TX_RETURN))
    else $error("overhead window not a single period before sampling");
  AST_STROBE_EVERY_BIT: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    (tx_state == FTONP_TX_IDLE && tx_req.dst_valid) |=> overhead_strobe_clock ##1
      !overhead_strobe_clock)
    else $error("strobe clock did not pulse for an overhead bit");
  AST_INSERT_TAKEN: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    (tx_state == FTONP_TX_WINDOW && overhead_insert_request && tx_insertable && !pkt_l)
      |=> tx_value == $past(tx_overhead_bit_in))
    else $error("inserted overhead bit not taken");
  AST_NO_REQUEST_IGNORED: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    (tx_state == FTONP_TX_WINDOW && !overhead_insert_request) |=> tx_value == $past(tx_default))
    else $error("overhead bit taken without insert request");
  AST_NOT_INSERTABLE: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    (tx_state == FTONP_TX_WINDOW && !tx_insertable) |=> tx_value == $past(tx_default))
    else $error("non-insertable overhead bit was replaced");
  AST_RX_VALID_PULSE: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    (oh_pulse && !pkt_l) |=> rx_overhead_valid ##1
      (!rx_overhead_valid || $past(pkt_l) || $past(oh_pulse)))
    else $error("receive overhead valid not one period wide");
  AST_PKT_PINS: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    pkt_l |=> rx_nibble_line == $past(rx_byte[PKT_BIT_NIB3:PKT_BIT_NIB0]) &&
      rx_overhead_valid == $past(rx_byte[PKT_BIT_OH_VALID]))
    else $error("packet byte bits not on shared pins");
  AST_NIBBLE_DATA: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    (rx_x.dst_valid && nib_l && !pkt_l) ##1 !pkt_l |=>
      rx_nibble_line == $past(rx_x.dst_data[PKT_W +: NIBBLE_W], 2))
    else $error("nibble lines do not carry the received nibble");
  AST_NIBBLE_STABLE: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    (!pkt_l && $stable(pkt_l) && $stable(rx_nib)) |=> $stable(rx_nibble_line))
    else $error("nibble lines changed without new data");
  AST_NIBBLE_MODE_ONLY: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    (rx_x.dst_valid && !nib_l) |=> rx_nib == NIBBLE_RST)
    else $error("payload on nibble lines outside nibble mode");
  AST_SHARED_PIN_SELECT: assert property (
    @(posedge transmit_input_clock) disable iff (link_rst)
    pkt_l |=> !overhead_window_oe && !overhead_window_out)
    else $error("window pin driven while packet controller enabled");
endmodule : ftonp_port
`default_nettype wire

// File: rtl/ftonp_xfer.sv
// toggle handshake that carries one word from one clock domain to another
`timescale 1ns/1ps
`default_nettype none
module ftonp_xfer #(
  parameter int WIDTH = 1
) (
  // source domain
  input  wire logic src_clk,
  input  wire logic src_rst,
  // destination domain
  input  wire logic dst_clk,
  input  wire logic dst_rst,
  // carrier
  ftonp_xfer_if.xfer port
);
  logic             req_tog;
  logic [WIDTH-1:0] hold;
  logic             ack_s1;
  logic             ack_s2;
  logic             req_s1;
  logic             req_s2;
  logic             req_s3;
  logic             ack_tog;
  logic             dst_valid;
  logic [WIDTH-1:0] dst_data;

  if (WIDTH < 1) begin : g_bad_width
    $error("ftonp_xfer: WIDTH must be at least 1");
  end

  // ***********************************************
  // source side
  // ***********************************************
  assign port.src_ready = (req_tog == ack_s2);

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      req_tog <= 1'b0;
      hold    <= '0;
    end else if (port.src_valid && port.src_ready) begin
      req_tog <= ~req_tog;
      hold    <= port.src_data;
    end
  end

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tog;
      ack_s2 <= ack_s1;
    end
  end

  // ***********************************************
  // destination side
  // ***********************************************
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      ack_tog <= 1'b0;
    end else begin
      req_s1 <= req_tog;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      ack_tog <= req_s3;
    end
  end

  // hold is stable while the request toggle is in flight
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      dst_valid <= 1'b0;
      dst_data  <= '0;
    end else begin
      dst_valid <= req_s2 ^ req_s3;
      if (req_s2 ^ req_s3) begin
        dst_data <= hold;
      end
    end
  end

  assign port.dst_valid = dst_valid;
  assign port.dst_data  = dst_data;
endmodule : ftonp_xfer
`default_nettype wire

// File: rtl/ftonp_xfer_if.sv
// word crossing carrier between the two clock domains
`timescale 1ns/1ps
`default_nettype none
interface ftonp_xfer_if #(
  parameter int WIDTH = 1
);
  logic             src_valid;
  logic             src_ready;
  logic [WIDTH-1:0] src_data;
  logic             dst_valid;
  logic [WIDTH-1:0] dst_data;
  modport xfer (input src_valid, input src_data, output src_ready,
                output dst_valid, output dst_data);
  modport src (output src_valid, output src_data, input src_ready);
  modport dst (input dst_valid, input dst_data);
endinterface : ftonp_xfer_if
`default_nettype wire

// File: test/ftonp_terminal_model.sv
// terminal equipment model that drives the transmit overhead pins
`timescale 1ns/1ps
`default_nettype none
module ftonp_terminal_model (
  // link side
  input  wire logic link_clk,
  input  wire logic overhead_window_out,
  output logic      overhead_insert_request,
  output logic      tx_overhead_bit_in,
  // scenario control
  input  wire logic pkt_mode,
  input  wire logic ins_en,
  input  wire logic ins_bit,
  input  wire logic pkt_bit4
);
  always @(negedge link_clk) begin
    if (pkt_mode) begin
      overhead_insert_request <= pkt_bit4;
      tx_overhead_bit_in      <= ins_bit;
    end else if (overhead_window_out && ins_en) begin
      overhead_insert_request <= 1'b1;
      tx_overhead_bit_in      <= ins_bit;
    end else begin
      // wrong-edge or unrequested samples pick up a value that differs from the expected one
      overhead_insert_request <= 1'b0;
      tx_overhead_bit_in      <= ins_bit ^ ins_en;
    end
  end
endmodule : ftonp_terminal_model
`default_nettype wire

// File: test/testbench.sv
// self-checking bench of the terminal overhead and nibble port
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ftonp_pkg::*;
;
  logic                sys_clk, sys_rst, link_clk, pkt_enable, nibble_mode;
  logic                core_oh_valid, core_oh_insertable, core_oh_default;
  logic                core_oh_ready, core_oh_done, core_oh_value;
  logic                core_rx_valid, core_rx_oh_flag, core_rx_oh_bit;
  logic                core_rx_ready, core_tx_pkt_bit4;
  logic [NIBBLE_W-1:0] core_rx_nibble, rx_nibble_line, nib_held;
  logic [PKT_W-1:0]    core_rx_pkt_byte;
  logic                overhead_insert_request, tx_overhead_bit_in, overhead_strobe_clock;
  logic                overhead_window_out, overhead_window_oe;
  logic                rx_overhead_valid, rx_overhead_bit_out;
  logic                ins_en, ins_bit, pkt_bit4, seen_bit;
  int                  failures, comparisons, strobes, windows, valids;

  ftonp_port u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .transmit_input_clock(link_clk),
    .pkt_enable(pkt_enable), .nibble_mode(nibble_mode), .core_oh_valid(core_oh_valid),
    .core_oh_insertable(core_oh_insertable), .core_oh_default(core_oh_default),
    .core_oh_ready(core_oh_ready), .core_oh_done(core_oh_done), .core_oh_value(core_oh_value),
    .core_rx_valid(core_rx_valid), .core_rx_oh_flag(core_rx_oh_flag),
    .core_rx_oh_bit(core_rx_oh_bit), .core_rx_nibble(core_rx_nibble),
    .core_rx_pkt_byte(core_rx_pkt_byte), .core_rx_ready(core_rx_ready),
    .core_tx_pkt_bit4(core_tx_pkt_bit4), .overhead_insert_request(overhead_insert_request),
    .tx_overhead_bit_in(tx_overhead_bit_in), .overhead_strobe_clock(overhead_strobe_clock),
    .overhead_window_in(1'b0), .overhead_window_out(overhead_window_out),
    .overhead_window_oe(overhead_window_oe), .rx_overhead_valid(rx_overhead_valid),
    .rx_overhead_bit_out(rx_overhead_bit_out), .rx_nibble_line(rx_nibble_line));

  ftonp_terminal_model u_term (.link_clk(link_clk), .overhead_window_out(overhead_window_out),
    .overhead_insert_request(overhead_insert_request), .tx_overhead_bit_in(tx_overhead_bit_in),
    .pkt_mode(pkt_enable), .ins_en(ins_en), .ins_bit(ins_bit), .pkt_bit4(pkt_bit4));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // expected final overhead bit
  function automatic logic exp_oh_bit(input logic insb, input logic dflt, input logic en,
                                      input logic b, input logic pkt);
    return (insb && en && !pkt) ? b : dflt;
  endfunction : exp_oh_bit

  // expected nibble pins for a received word
  function automatic logic [3:0] exp_nibble(input logic pkt, input logic nib,
                                            input logic [3:0] n, input logic [7:0] pb);
    return pkt ? pb[3:0] : (nib ? n : 4'h0);
  endfunction : exp_nibble

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ***********************************************
  // link side monitors
  // ***********************************************
  always @(posedge link_clk) begin
    #20;
    nib_held = rx_nibble_line;
  end
  always @(negedge link_clk) begin
    if (overhead_strobe_clock === 1'b1) strobes++;
    if (overhead_window_out === 1'b1) windows++;
    if (rx_overhead_valid === 1'b1) begin
      valids++;
      seen_bit = rx_overhead_bit_out;
    end
    check("nibble hold", nib_held, rx_nibble_line);
  end

  task automatic oh_bit(input logic insb, input logic dflt, input logic en, input logic b);
    logic exp;
    exp = exp_oh_bit(insb, dflt, en, b, pkt_enable);
    repeat (600) if (core_oh_ready !== 1'b1) @(negedge sys_clk);
    strobes = 0;
    windows = 0;
    @(posedge sys_clk);
    core_oh_valid      <= 1'b1;
    core_oh_insertable <= insb;
    core_oh_default    <= dflt;
    ins_en             <= en;
    ins_bit            <= b;
    @(posedge sys_clk);
    core_oh_valid <= 1'b0;
    repeat (600) begin
      @(negedge sys_clk);
      if (core_oh_done === 1'b1) break;
    end
    check("overhead done", 1'b1, core_oh_done);
    check("overhead value", exp, core_oh_value);
    check("strobe count", 8'h01, 8'(strobes));
    check("window count", !pkt_enable, 8'(windows));
    check("window enable", !pkt_enable, overhead_window_oe);
  endtask : oh_bit

  task automatic rx_word(input logic f, input logic b, input logic [3:0] n, input logic [7:0] pb);
    logic [3:0] exp;
    exp = exp_nibble(pkt_enable, nibble_mode, n, pb);
    repeat (600) if (core_rx_ready !== 1'b1) @(negedge sys_clk);
    valids = 0;
    seen_bit = ~b;
    @(posedge sys_clk);
    core_rx_valid    <= 1'b1;
    core_rx_oh_flag  <= f;
    core_rx_oh_bit   <= b;
    core_rx_nibble   <= n;
    core_rx_pkt_byte <= pb;
    @(posedge sys_clk);
    core_rx_valid <= 1'b0;
    repeat (10) @(negedge link_clk);
    check("nibble lines", exp, rx_nibble_line);
    if (pkt_enable) begin
      check("valid pin", pb[PKT_BIT_OH_VALID], rx_overhead_valid);
      check("overhead bit pin", 1'b0, rx_overhead_bit_out);
    end else begin
      check("valid pulses", f, 8'(valids));
      if (f) check("overhead bit", b, seen_bit);
    end
  endtask : rx_word

  initial begin
    failures = 0;
    comparisons = 0;
    {sys_rst, pkt_enable, nibble_mode, core_oh_valid, core_oh_insertable} = 5'h10;
    {core_oh_default, core_rx_valid, core_rx_oh_flag, core_rx_oh_bit} = 4'h0;
    {ins_en, ins_bit, pkt_bit4} = 3'h0;
    core_rx_nibble = 4'h0;
    core_rx_pkt_byte = 8'h00;
    void'($urandom(32'hAADE));
    repeat (20) @(posedge sys_clk);
    repeat (4) @(posedge link_clk);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    for (int m = 0; m < 8; m++) oh_bit(m[2], m[1], m[0], ~m[1]);
    repeat (12) oh_bit(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    for (int m = 0; m < 3; m++) begin
      @(posedge sys_clk);
      nibble_mode <= (m == 1);
      pkt_enable  <= (m == 2);
      repeat (6) @(posedge link_clk);
      rx_word(1'b1, 1'b1, 4'hF, 8'hFF);
      repeat (4) rx_word(1'($urandom), 1'($urandom), 4'($urandom), 8'($urandom));
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      pkt_bit4 <= k[0];
      repeat (4) @(posedge link_clk);
      repeat (8) @(negedge sys_clk);
      check("packet bit4", k[0], core_tx_pkt_bit4);
      oh_bit(1'b1, 1'b0, 1'b1, 1'b1);
    end
    give_verdict();
  end

  initial begin
    #300000;
    failures++;
    $display("unexpected watchdog expiry");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
